// [core/sync_serial_port.sv]
// synchronous serial port: axi4-lite registers, two sample stores,
// bit engine and receive idle timer
// assumes the pin level resolution is done outside from the enables
//
// Contract
// - bit clock driven in master mode, taken from pin in slave mode.
// - frame indicator driven in master mode, taken from pin otherwise.
// - disabled port releases every serial pin.
// - separate transmit and receive stores, sixteen 32-bit entries each.
// - sample width programmable from four to thirty-two bits.
// - full duplex for most formats, half duplex for messaging format.
// - each data port access is a full word moving one entry.
// - bits above sample size dropped on write, read as zero.
// - data port read pops receive store, write pushes transmit store.
// - transmit threshold raises interrupt and dma request when enabled.
// - receive threshold raises interrupt and dma request when enabled.
// - timeout flag sets after receive store idles for programmed period.
// - idle timer restarts on new sample or receive store read.
// - timeout flag cleared only by writing one.
// - timeout interrupt is flag and enable, drops when enable clears.
// - trailing samples raise no dma; software drains by level.
// - words shifted most significant bit first.
`timescale 1ns/1ps
module sync_serial_port #(
   parameter int DEPTH = serial_port_pkg::FIFO_DEPTH,
   parameter int HALF_BIT = serial_port_pkg::HALF_BIT_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [serial_port_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [serial_port_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [serial_port_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [serial_port_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_bit_clock_in,
   output logic serial_bit_clock_out,
   output logic serial_bit_clock_oe,
   input wire logic frame_indicator_in,
   output logic frame_indicator_out,
   output logic frame_indicator_oe,
   input wire logic data_pin_a_in,
   output logic data_pin_a_out,
   output logic data_pin_a_oe,
   input wire logic data_pin_b_in,
   output logic data_pin_b_out,
   output logic data_pin_b_oe,
   output logic tx_level_irq,
   output logic rx_level_irq,
   output logic tx_dma_req,
   output logic rx_dma_req,
   output logic timeout_irq
);
   import serial_port_pkg::*;

   localparam int LVL_W = $clog2(DEPTH) + 1;

   logic [DATA_W-1:0] control_reg_a_ff;
   logic [DATA_W-1:0] control_reg_b_ff;
   logic [LIMIT_W-1:0] rx_idle_limit_ff;
   logic timeout_flag_ff;
   logic [LIMIT_W-1:0] idle_cnt_ff;
   logic swap_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic aw_held_ff;
   logic [DATA_W-1:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic w_held_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [2:0] clk_sync_ff;
   logic [2:0] frm_sync_ff;
   logic [1:0] din_a_sync_ff;
   logic [1:0] din_b_sync_ff;
   link_state_e state_ff;
   logic bit_clk_ff;
   logic frm_ff;
   logic [$clog2(HALF_BIT+1)-1:0] div_ff;
   logic [DATA_W-1:0] tx_sh_ff;
   logic [DATA_W-1:0] rx_sh_ff;
   logic [SIZE_W-1:0] bits_ff;
   logic wr_fire;
   logic rd_fire;
   logic enable;
   logic clk_slave;
   logic frm_slave;
   logic half_duplex;
   logic [SIZE_W-1:0] size;
   logic [DATA_W-1:0] size_mask;
   logic tick;
   logic rise_ev;
   logic fall_ev;
   logic start_ev;
   logic done_ev;
   logic serial_din;
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   logic [DATA_W-1:0] tx_dout;
   logic [DATA_W-1:0] rx_dout;
   logic [LVL_W-1:0] tx_level;
   logic [LVL_W-1:0] rx_level;
   logic tx_full;
   logic tx_empty;
   logic rx_full;
   logic rx_empty;
   logic tx_req;
   logic rx_req;
   logic timeout_hit;
   logic timeout_clr;
   logic [DATA_W-1:0] status_word;

   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] nxt,
      input logic [3:0] strb
   );
      logic [DATA_W-1:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nxt[8*i +: 8];
         end
      end
      return res;
   endfunction : merge

   assign enable = control_reg_a_ff[A_ENABLE];
   assign clk_slave = control_reg_b_ff[B_CLK_DIR];
   assign frm_slave = control_reg_b_ff[B_FRM_DIR];
   assign half_duplex = (control_reg_a_ff[A_FMT_LO +: 2] == FMT_MESSAGING);

   always_comb begin
      size = {control_reg_a_ff[A_SIZE_EXT],
              control_reg_a_ff[A_SIZE_LO +: 4]} + 6'h01;
      if (size < MIN_SAMPLE) begin
         size = MIN_SAMPLE;
      end
      size_mask = '0;
      for (int i = 0; i < DATA_W; i++) begin
         size_mask[i] = (i < int'(size));
      end
   end

   // register bus: address and data may arrive in either order
   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready = !w_held_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held_ff <= 1'b0;
         awaddr_ff <= '0;
         w_held_ff <= 1'b0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         case (awaddr_ff)
            CONTROL_REG_A_OFS, CONTROL_REG_B_OFS, STATUS_REG_OFS,
            DATA_PORT_OFS, RX_IDLE_LIMIT_OFS: bresp_ff <= RESP_OKAY;
            default: bresp_ff <= RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         control_reg_a_ff <= CONTROL_REG_A_RST;
         control_reg_b_ff <= CONTROL_REG_B_RST;
         rx_idle_limit_ff <= RX_IDLE_LIMIT_RST;
      end else if (wr_fire) begin
         if (awaddr_ff == CONTROL_REG_A_OFS) begin
            control_reg_a_ff <= merge(control_reg_a_ff, wdata_ff, wstrb_ff)
                                & CONTROL_REG_A_MASK;
         end
         if (awaddr_ff == CONTROL_REG_B_OFS) begin
            control_reg_b_ff <= merge(control_reg_b_ff, wdata_ff, wstrb_ff)
                                & CONTROL_REG_B_MASK;
         end
         if (awaddr_ff == RX_IDLE_LIMIT_OFS) begin
            rx_idle_limit_ff <= LIMIT_W'(merge(DATA_W'(rx_idle_limit_ff),
                                               wdata_ff, wstrb_ff));
         end
      end
   end

   // full word only; upper bits dropped; write pushes
   assign tx_push = wr_fire && (awaddr_ff == DATA_PORT_OFS)
                    && (wstrb_ff == 4'hF);
   assign rx_pop = rd_fire && (s_axi_araddr == DATA_PORT_OFS) && !rx_empty;

   assign tx_req = (tx_level <= LVL_W'(control_reg_b_ff[B_TX_THR_LO +: 4]));
   assign rx_req = (rx_level > LVL_W'(control_reg_b_ff[B_RX_THR_LO +: 4]));

   always_comb begin
      status_word = '0;
      status_word[S_RX_LEVEL_LO +: LVL_W] = rx_level;
      status_word[S_RX_HAS] = !rx_empty;
      status_word[S_TX_LEVEL_LO +: LVL_W] = tx_level;
      status_word[S_TX_NOT_FULL] = !tx_full;
      status_word[S_BUSY] = (state_ff == ST_RUN);
      status_word[S_TIMEOUT] = timeout_flag_ff;
      status_word[S_TX_REQ] = tx_req;
      status_word[S_RX_REQ] = rx_req;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= RESP_OKAY;
         case (s_axi_araddr)
            CONTROL_REG_A_OFS: rdata_ff <= control_reg_a_ff;
            CONTROL_REG_B_OFS: rdata_ff <= control_reg_b_ff;
            STATUS_REG_OFS: rdata_ff <= status_word;
            DATA_PORT_OFS: rdata_ff <= rx_empty ? '0 : (rx_dout & size_mask);
            RX_IDLE_LIMIT_OFS: rdata_ff <= DATA_W'(rx_idle_limit_ff);
            default: begin
               rdata_ff <= '0;
               rresp_ff <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   sample_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) tx_store (
      .mclk(mclk),
      .rst_b(rst_b),
      .push(tx_push),
      .din(wdata_ff & size_mask),
      .pop(tx_pop),
      .dout(tx_dout),
      .level(tx_level),
      .full(tx_full),
      .empty(tx_empty)
   );

   sample_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) rx_store (
      .mclk(mclk),
      .rst_b(rst_b),
      .push(rx_push),
      .din(rx_sh_ff & size_mask),
      .pop(rx_pop),
      .dout(rx_dout),
      .level(rx_level),
      .full(rx_full),
      .empty(rx_empty)
   );

   // pins from outside pass two flops; the third flop only feeds edges
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         clk_sync_ff <= '0;
         frm_sync_ff <= 3'h7;
         din_a_sync_ff <= '0;
         din_b_sync_ff <= '0;
      end else begin
         clk_sync_ff <= {clk_sync_ff[1:0], serial_bit_clock_in};
         frm_sync_ff <= {frm_sync_ff[1:0], frame_indicator_in};
         din_a_sync_ff <= {din_a_sync_ff[0], data_pin_a_in};
         din_b_sync_ff <= {din_b_sync_ff[0], data_pin_b_in};
      end
   end

   // swap taken over only while idle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         swap_ff <= 1'b0;
      end else if (state_ff == ST_IDLE) begin
         swap_ff <= control_reg_b_ff[B_SWAP];
      end
   end

   assign serial_din = swap_ff ? din_a_sync_ff[1] : din_b_sync_ff[1];

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         div_ff <= '0;
      end else if (state_ff != ST_RUN || tick) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_ff + 1'b1;
      end
   end
   assign tick = (state_ff == ST_RUN)
                 && (div_ff == ($clog2(HALF_BIT+1))'(HALF_BIT - 1));

   // edges from own divider or from the synchronised pin
   assign rise_ev = (state_ff == ST_RUN) && (clk_slave ?
                    (clk_sync_ff[1] && !clk_sync_ff[2]) : (tick && !bit_clk_ff));
   assign fall_ev = (state_ff == ST_RUN) && (clk_slave ?
                    (!clk_sync_ff[1] && clk_sync_ff[2]) : (tick && bit_clk_ff));
   // frame start from own store or the pin's falling edge
   assign start_ev = enable && (state_ff == ST_IDLE) && (frm_slave ?
                     (!frm_sync_ff[1] && frm_sync_ff[2]) : !tx_empty);
   assign done_ev = fall_ev && (bits_ff == size);
   assign tx_pop = start_ev;
   assign rx_push = done_ev && !half_duplex;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ST_IDLE;
         bit_clk_ff <= 1'b0;
         frm_ff <= 1'b1;
         bits_ff <= '0;
         tx_sh_ff <= '0;
         rx_sh_ff <= '0;
      end else if (!enable) begin
         state_ff <= ST_IDLE;
         bit_clk_ff <= 1'b0;
         frm_ff <= 1'b1;
         bits_ff <= '0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (start_ev) begin
                  state_ff <= ST_RUN;
                  frm_ff <= 1'b0;
                  bits_ff <= '0;
                  rx_sh_ff <= '0;
                  // word left aligned so bit 31 leaves first
                  tx_sh_ff <= tx_empty ? '0 :
                              ((tx_dout & size_mask) << (MAX_SAMPLE - size));
               end
            end
            ST_RUN: begin
               if (tick) begin
                  bit_clk_ff <= !bit_clk_ff;
               end
               if (rise_ev) begin
                  rx_sh_ff <= {rx_sh_ff[DATA_W-2:0], serial_din};
                  bits_ff <= bits_ff + 1'b1;
               end
               if (fall_ev) begin
                  tx_sh_ff <= {tx_sh_ff[DATA_W-2:0], 1'b0};
               end
               if (done_ev) begin
                  state_ff <= ST_IDLE;
                  frm_ff <= 1'b1;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   assign serial_bit_clock_out = bit_clk_ff;
   assign serial_bit_clock_oe = enable && !clk_slave;
   assign frame_indicator_out = frm_ff;
   assign frame_indicator_oe = enable && !frm_slave;
   assign data_pin_a_out = swap_ff ? 1'b0 : tx_sh_ff[DATA_W-1];
   assign data_pin_a_oe = enable && !swap_ff;
   assign data_pin_b_out = swap_ff ? tx_sh_ff[DATA_W-1] : 1'b0;
   assign data_pin_b_oe = enable && swap_ff;

   assign tx_level_irq = enable && tx_req && control_reg_b_ff[B_TX_IRQ_EN];
   assign tx_dma_req = enable && tx_req && control_reg_b_ff[B_TX_DMA_EN];
   assign rx_level_irq = rx_req && control_reg_b_ff[B_RX_IRQ_EN];
   assign rx_dma_req = rx_req && control_reg_b_ff[B_RX_DMA_EN];

   // restart on push or pop; runs only with data held
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         idle_cnt_ff <= '0;
      end else if (rx_push || rx_pop || rx_empty) begin
         idle_cnt_ff <= '0;
      // step once past the limit so the hit is a pulse and a clear sticks
      end else if ((idle_cnt_ff <= rx_idle_limit_ff) && !(&idle_cnt_ff)) begin
         idle_cnt_ff <= idle_cnt_ff + 1'b1;
      end
   end

   // limit of zero keeps the timer off
   assign timeout_hit = !rx_empty && (rx_idle_limit_ff != '0)
                        && (idle_cnt_ff == rx_idle_limit_ff);
   assign timeout_clr = wr_fire && (awaddr_ff == STATUS_REG_OFS)
                        && wstrb_ff[S_TIMEOUT/8] && wdata_ff[S_TIMEOUT];

   // write one clears; a fresh hit wins over the clear
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         timeout_flag_ff <= 1'b0;
      end else if (timeout_hit && !rx_push && !rx_pop) begin
         timeout_flag_ff <= 1'b1;
      end else if (timeout_clr) begin
         timeout_flag_ff <= 1'b0;
      end
   end

   // flag gated by enable, no storage
   assign timeout_irq = timeout_flag_ff && control_reg_b_ff[B_TO_IRQ_EN];
endmodule : sync_serial_port

// [core/serial_port_pkg.sv]
// constants, register map and field layout of the synchronous serial port
// assumes a 32-bit axi4-lite register bus and one 50 MHz clock
package serial_port_pkg;
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 16;
   localparam int ADDR_W = 8;
   localparam int LIMIT_W = 24;
   localparam int SIZE_W = 6;
   // register byte addresses
   localparam logic [ADDR_W-1:0] CONTROL_REG_A_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] CONTROL_REG_B_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] STATUS_REG_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] DATA_PORT_OFS = 8'h0C;
   localparam logic [ADDR_W-1:0] RX_IDLE_LIMIT_OFS = 8'h10;
   // control_reg_a fields
   localparam int A_ENABLE = 0;
   localparam int A_SIZE_LO = 1;
   localparam int A_SIZE_EXT = 5;
   localparam int A_FMT_LO = 6;
   localparam logic [DATA_W-1:0] CONTROL_REG_A_RST = 32'h0000_001E;
   localparam logic [DATA_W-1:0] CONTROL_REG_A_MASK = 32'h0000_00FF;
   // control_reg_b fields
   localparam int B_CLK_DIR = 0;
   localparam int B_FRM_DIR = 1;
   localparam int B_SWAP = 2;
   localparam int B_TX_IRQ_EN = 3;
   localparam int B_RX_IRQ_EN = 4;
   localparam int B_TX_DMA_EN = 5;
   localparam int B_RX_DMA_EN = 6;
   localparam int B_TO_IRQ_EN = 7;
   localparam int B_TX_THR_LO = 8;
   localparam int B_RX_THR_LO = 12;
   localparam logic [DATA_W-1:0] CONTROL_REG_B_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] CONTROL_REG_B_MASK = 32'h0000_FFFF;
   // status_reg fields
   localparam int S_RX_LEVEL_LO = 0;
   localparam int S_RX_HAS = 5;
   localparam int S_TX_LEVEL_LO = 6;
   localparam int S_TX_NOT_FULL = 11;
   localparam int S_BUSY = 12;
   localparam int S_TIMEOUT = 13;
   localparam int S_TX_REQ = 14;
   localparam int S_RX_REQ = 15;
   localparam logic [LIMIT_W-1:0] RX_IDLE_LIMIT_RST = 24'h000000;
   // master bit clock half period in mclk cycles; kept above the two-flop
   // input delay so read data has settled by the sampling edge
   localparam int HALF_BIT_CYCLES = 4;
   localparam logic [SIZE_W-1:0] MIN_SAMPLE = 6'h04;
   localparam logic [SIZE_W-1:0] MAX_SAMPLE = 6'h20;
   localparam logic [1:0] FMT_MESSAGING = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } link_state_e;
endpackage : serial_port_pkg

// [core/sample_fifo.sv]
// first-in first-out store for serial samples
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic push,
   input wire logic [WIDTH-1:0] din,
   input wire logic pop,
   output logic [WIDTH-1:0] dout,
   output logic [$clog2(DEPTH):0] level,
   output logic full,
   output logic empty
);
   localparam int PTR_W = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr_ff;
   logic [PTR_W-1:0] rd_ptr_ff;
   logic [PTR_W:0] count_ff;
   logic do_push;
   logic do_pop;

   // a push into a full store or a pop from an empty one is dropped
   assign do_push = push && !full;
   assign do_pop = pop && !empty;
   assign full = (count_ff == (PTR_W+1)'(DEPTH));
   assign empty = (count_ff == '0);
   assign level = count_ff;
   assign dout = mem[rd_ptr_ff];

   always_ff @(posedge mclk) begin
      if (do_push) begin
         mem[wr_ptr_ff] <= din;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         if (do_push && !do_pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (do_pop && !do_push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule : sample_fifo

// [test/sync_serial_port_assertions.sv]
// bus handshake and pin direction checks for the serial port
// assumes one mclk domain and the active-low rst_b
`timescale 1ns/1ps
module sync_serial_port_assertions (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_bit_clock_out,
   input wire logic serial_bit_clock_oe,
   input wire logic frame_indicator_oe,
   input wire logic data_pin_a_oe,
   input wire logic data_pin_b_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read response late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped early");
   data_pins_a: assert property (!(data_pin_a_oe && data_pin_b_oe))
      else $error("both data pins driven");
   released_pins_a: assert property (!data_pin_a_oe && !data_pin_b_oe |-> !serial_bit_clock_oe)
      else $error("clock driven while disabled");
   frame_drive_a: assert property (frame_indicator_oe |-> data_pin_a_oe || data_pin_b_oe)
      else $error("frame driven while disabled");
   // a master half period spans at least two cycles
   master_clock_a: assert property (serial_bit_clock_oe && $changed(serial_bit_clock_out) |=> $stable(serial_bit_clock_out))
      else $error("bit clock toggles too fast");
endmodule : sync_serial_port_assertions
bind sync_serial_port sync_serial_port_assertions checker_i (.*);

// [test/serial_peer_model.sv]
// converter on the serial side, slave to bit clock and frame
// assumes frame low while selected
`timescale 1ns/1ps
module serial_peer_model (
   input wire logic sck,
   input wire logic frm_n,
   input wire logic sdi,
   input wire logic [31:0] reply,
   output logic sdo,
   output logic [31:0] got
);
   logic [31:0] sh;
   initial sdo = 1'b0;
   always @(negedge frm_n) begin
      sh = reply;
      sdo = reply[31];
   end
   always @(posedge sck) if (!frm_n) got = {got[30:0], sdi};
   always @(negedge sck) if (!frm_n) begin
      sh = sh << 1;
      sdo = sh[31];
   end
   // released line must not look like held data
   always @(posedge frm_n) sdo = ~sdo;
endmodule : serial_peer_model

// [test/sync_serial_fifo_access_tb.sv]
// bench for the serial port: bus tasks, peer on the pins, verdict
// assumes the peer model and checker compile first
`timescale 1ns/1ps
module sync_serial_fifo_access_tb;
   import serial_port_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, ext_ck = 1'b0, sdo;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = '0, reply = '0, s_axi_rdata, rdat, got;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic serial_bit_clock_in, serial_bit_clock_out, serial_bit_clock_oe;
   logic frame_indicator_in, frame_indicator_out, frame_indicator_oe;
   logic data_pin_a_in, data_pin_a_out, data_pin_a_oe;
   logic data_pin_b_in, data_pin_b_out, data_pin_b_oe;
   logic tx_level_irq, rx_level_irq, tx_dma_req, rx_dma_req, timeout_irq;
   int seed = 6, fail_count = 0, tests_run = 0;
   // undriven lines follow the peer; frame pin has a pull-up
   assign serial_bit_clock_in = serial_bit_clock_oe ? serial_bit_clock_out
      : ext_ck;
   assign frame_indicator_in = !frame_indicator_oe | frame_indicator_out;
   assign data_pin_a_in = data_pin_a_oe ? data_pin_a_out : sdo;
   assign data_pin_b_in = data_pin_b_oe ? data_pin_b_out : sdo;
   sync_serial_port dut (.*);
   serial_peer_model peer (.sck(serial_bit_clock_in),
      .frm_n(frame_indicator_in), .reply(reply), .sdo(sdo), .got(got),
      .sdi(data_pin_a_oe ? data_pin_a_in : data_pin_b_in));
   initial forever #10 mclk = ~mclk;
   // peer clock runs only inside frames, phase unrelated to mclk
   initial begin
      #3;
      forever #80 ext_ck = !frame_indicator_in ? ~ext_ck : 1'b0;
   end
   initial begin
      #400000;
      fail_count++;
      results();
   end
   function automatic logic [31:0] fit(input logic [31:0] v, input int s);
      return (s == 32) ? v : v & ((32'h1 << s) - 32'h1);
   endfunction : fit
   task automatic check(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_arvalid <= !w;
      forever begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         rdat = s_axi_rdata;
         rsp = w ? s_axi_bresp : s_axi_rresp;
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_rvalid && s_axi_rready) break;
         s_axi_bready <= s_axi_bvalid;
         s_axi_rready <= s_axi_rvalid;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
   endtask : bus
   task automatic xfer(input int s, input logic [1:0] f,
      input logic [15:0] b, input logic back);
      logic [31:0] d;
      d = $random(seed);
      reply = $random(seed);
      bus(1'b1, CONTROL_REG_B_OFS, {16'h0000, b});
      bus(1'b1, CONTROL_REG_A_OFS, {24'h000000, f, 5'(s - 1), 1'b1});
      check("swap", data_pin_b_oe, b[B_SWAP]);
      bus(1'b1, DATA_PORT_OFS, d);
      wait (frame_indicator_in === 1'b0);
      @(posedge frame_indicator_in);
      repeat (4) @(posedge mclk);
      check("serial out", fit(got, s), fit(d, s));
      if (back) begin
         bus(1'b0, DATA_PORT_OFS, '0);
         check("rx word", rdat, (f == FMT_MESSAGING) ? 32'h0 : fit(reply >> (32 - s), s));
      end
   endtask : xfer
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   initial begin
      int sz[4] = '{4, 13, 32, 8};
      logic [15:0] bb[4] = '{16'h0000, 16'h0004, 16'h0001, 16'h0000};
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      bus(1'b0, CONTROL_REG_A_OFS, '0);
      check("ctrl a", rdat, CONTROL_REG_A_RST);
      bus(1'b0, 8'h14, '0);
      check("unmapped", rdat, 32'h0);
      check("rresp", rsp, RESP_SLVERR);
      bus(1'b1, 8'h14, 32'hFFFF_FFFF);
      check("bresp", rsp, RESP_SLVERR);
      for (int i = 0; i < 4; i++)
         xfer(sz[i], (i == 3) ? FMT_MESSAGING : 2'h0, bb[i], 1'b1);
      // limit 200 cycles, rx threshold 1
      bus(1'b1, RX_IDLE_LIMIT_OFS, 32'h0000_00C8);
      xfer(8, 2'h0, 16'h10D0, 1'b0);
      check("rx req low", rx_dma_req, 1'b0);
      xfer(8, 2'h0, 16'h10D0, 1'b0);
      check("rx req", {rx_dma_req, rx_level_irq}, 2'b11);
      repeat (170) @(posedge mclk);
      check("restart", timeout_irq, 1'b0);
      repeat (60) @(posedge mclk);
      check("timeout", timeout_irq, 1'b1);
      bus(1'b1, STATUS_REG_OFS, '0);
      check("w0 keeps", timeout_irq, 1'b1);
      bus(1'b1, CONTROL_REG_B_OFS, 32'h0000_1050);
      check("irq off", timeout_irq, 1'b0);
      bus(1'b1, STATUS_REG_OFS, 32'h0000_2000);
      bus(1'b0, STATUS_REG_OFS, '0);
      check("drain", rdat & 32'h0000_203F, 32'h0000_0022);
      bus(1'b1, CONTROL_REG_A_OFS, 32'h0000_000E);
      for (int i = 0; i < 17; i++) bus(1'b1, DATA_PORT_OFS, $random(seed));
      bus(1'b0, STATUS_REG_OFS, '0);
      check("tx full", rdat & 32'h0000_0FC0, 32'h0000_0400);
      bus(1'b1, CONTROL_REG_B_OFS, 32'h0000_0028);
      check("tx req off", tx_dma_req, 1'b0);
      bus(1'b1, CONTROL_REG_A_OFS, 32'h0000_000F);
      repeat (1200) @(posedge mclk);
      check("tx req", {tx_dma_req, tx_level_irq}, 2'b11);
      results();
   end
endmodule : sync_serial_fifo_access_tb
